// [verilog/rtcb_pkg.sv]
// Constants and carrier types for the backup-domain calendar clock.
// Assumes one 10 MHz core clock and slow source pins.
package rtcb_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NUM_BKP = 16;
  localparam int BKP_W = 32;
  localparam int BKP_IDX_W = 4;
  localparam int NUM_TAMP = 3;
  localparam int WUT_W = 17;
  localparam int PRA_W = 7;
  localparam int PRS_W = 15;
  localparam int CALW_W = 20;
  localparam int CALM_W = 9;
  localparam int CLK_HZ = 10_000_000;
  localparam int HSE_DIV = 32;
  localparam logic [4:0] HSE_DIV_LAST = 5'(HSE_DIV - 1);
  localparam logic [5:0] REF50_LAST = 6'h31;
  localparam logic [5:0] REF60_LAST = 6'h3b;
  localparam logic [PRS_W-1:0] REF_WIN = 15'h0007;
  localparam logic [10:0] CAL_ADD_PT = 11'h400;
  localparam logic [3:0] WU_DIV_LAST = 4'hf;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [PRA_W-1:0] PRA_RST = 7'h7f;
  localparam logic [PRS_W-1:0] PRS_RST = 15'h00ff;
  localparam logic [7:0] YEAR_RST = 8'h00;
  localparam logic [7:0] MON_RST = 8'h01;
  localparam logic [7:0] DATE_RST = 8'h01;
  localparam logic [2:0] WDAY_RST = 3'h1;
  // ****************************************
  // Flag indices
  // ****************************************
  localparam int FL_ALRA = 0;
  localparam int FL_ALRB = 1;
  localparam int FL_WUT = 2;
  localparam int FL_TS = 3;
  localparam int FL_TAMP = 4;
  localparam int NUM_FL = 7;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SRC_XTAL, SRC_LSRC, SRC_HSE32} rtcb_src_e;
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] wday;
    logic pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcb_cal_s;
  typedef struct packed {
    logic [3:0] msk;
    logic [7:0] date;
    logic pm;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcb_alarm_s;
endpackage

// [verilog/rtcb_top.sv]
// Calendar clock with alarms, tamper, timestamp, wakeup, backup words.
// Assumes source and event pins toggle far slower than clk_i / 4.
`timescale 1ns/1ps
module rtcb_top
  import rtcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic xtal_clk_i,
  input wire logic lsrc_clk_i,
  input wire logic hse_clk_i,
  input wire rtcb_src_e src_sel_i,
  input wire logic [PRA_W-1:0] prediv_a_i,
  input wire logic [PRS_W-1:0] prediv_s_i,
  input wire logic fmt12_i,
  input wire logic cal_load_i,
  input wire rtcb_cal_s cal_wdata_i,
  input wire logic ref_en_i,
  input wire logic ref60_i,
  input wire logic ref_clk_i,
  input wire logic shift_i,
  input wire logic [PRS_W-1:0] shift_sub_i,
  input wire logic shift_add1s_i,
  input wire logic [CALM_W-1:0] cal_minus_i,
  input wire logic cal_plus_i,
  input wire logic [1:0] alarm_en_i,
  input wire rtcb_alarm_s alarm_a_i,
  input wire rtcb_alarm_s alarm_b_i,
  input wire logic [NUM_TAMP-1:0] tamp_i,
  input wire logic [1:0] tamp_flt_i,
  input wire logic tamp_ts_en_i,
  input wire logic ts_i,
  input wire logic wut_en_i,
  input wire logic wut_1hz_i,
  input wire logic [WUT_W-1:0] wut_reload_i,
  input wire logic [NUM_FL-1:0] flag_clr_i,
  input wire logic [NUM_FL-1:0] wake_en_i,
  input wire logic bkp_we_i,
  input wire logic [BKP_IDX_W-1:0] bkp_idx_i,
  input wire logic [BKP_W-1:0] bkp_wdata_i,
  output logic [BKP_W-1:0] bkp_rdata_o,
  output rtcb_cal_s cal_o,
  output logic [PRS_W-1:0] subsec_o,
  output rtcb_cal_s ts_cal_o,
  output logic [PRS_W-1:0] ts_subsec_o,
  output logic [NUM_FL-1:0] flags_o,
  output logic wake_o
);
  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  localparam int NPIN = 5 + NUM_TAMP;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q;
  logic [NPIN-1:0] pin_rise;
  assign pin_raw = {tamp_i, ts_i, ref_clk_i, hse_clk_i, lsrc_clk_i,
    xtal_clk_i};
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign pin_rise = s2_q & ~s3_q;

  // ****************************************
  // Clock source selection
  // ****************************************
  logic [4:0] hse_div_q;
  logic hse_tick, raw_tick;
  assign hse_tick = pin_rise[2] && (hse_div_q == HSE_DIV_LAST);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) hse_div_q <= '0;
    else if (pin_rise[2]) hse_div_q <= hse_div_q + 5'h1;
  end
  assign raw_tick = (src_sel_i == SRC_XTAL) ? pin_rise[0] :
                    (src_sel_i == SRC_LSRC) ? pin_rise[1] : hse_tick;

  // ****************************************
  // Smooth calibration
  // ****************************************
  logic [CALW_W-1:0] calw_q;
  logic cal_drop, cal_add, add_pend_q, tick;
  // drop or add pulses per window
  assign cal_drop = (calw_q[10:0] == 11'h000) &&
                    (calw_q[19:11] < cal_minus_i);
  assign cal_add = cal_plus_i && (calw_q[10:0] == CAL_ADD_PT);
  assign tick = (raw_tick && !cal_drop) || add_pend_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      calw_q <= '0;
      add_pend_q <= 1'b0;
    end else begin
      if (raw_tick) calw_q <= calw_q + 20'h0_0001;
      add_pend_q <= raw_tick && cal_add;
    end
  end

  // ****************************************
  // Prescalers and reference clock
  // ****************************************
  logic [PRA_W-1:0] pra_q;
  logic [PRS_W-1:0] prs_q;
  logic [5:0] ref_cnt_q;
  logic apre_tick, ref_sec, ref_force, sec_tick;
  assign apre_tick = tick && (pra_q == '0);
  assign ref_sec = pin_rise[3] &&
                   (ref_cnt_q == (ref60_i ? REF60_LAST : REF50_LAST));
  assign ref_force = ref_en_i && ref_sec && (prs_q != '0) &&
                     (prs_q <= REF_WIN);
  assign sec_tick = (apre_tick && (prs_q == '0)) || ref_force ||
                    (shift_i && shift_add1s_i);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pra_q <= PRA_RST;
      prs_q <= PRS_RST;
      ref_cnt_q <= '0;
    end else begin
      if (pin_rise[3]) ref_cnt_q <= ref_sec ? 6'h00 : ref_cnt_q + 6'h01;
      if (tick) pra_q <= (pra_q == '0) ? prediv_a_i : pra_q - 7'h01;
      if (shift_i) prs_q <= prs_q + shift_sub_i;
      else if (ref_force) prs_q <= prediv_s_i;
      else if (apre_tick) begin
        prs_q <= (prs_q == '0) ? prediv_s_i : prs_q - 15'h0001;
      end
    end
  end

  // ****************************************
  // BCD calendar
  // ****************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction
  rtcb_cal_s cal_q, cal_d;
  logic leap, sec_wrap, min_wrap, hr_wrap, day_wrap;
  logic [7:0] last_day;
  assign leap = cal_q.year[4] ? (cal_q.year[3:0] == 4'h2 ||
                cal_q.year[3:0] == 4'h6) : (cal_q.year[3:0] == 4'h0 ||
                cal_q.year[3:0] == 4'h4 || cal_q.year[3:0] == 4'h8);
  assign last_day = (cal_q.month == 8'h02) ? (leap ? 8'h29 : 8'h28) :
                    (cal_q.month == 8'h04 || cal_q.month == 8'h06 ||
                     cal_q.month == 8'h09 || cal_q.month == 8'h11) ?
                    8'h30 : 8'h31;
  assign sec_wrap = cal_q.sec == 8'h59;
  assign min_wrap = sec_wrap && cal_q.min == 8'h59;
  assign hr_wrap = min_wrap && (fmt12_i ?
                   (cal_q.hour == 8'h11 && cal_q.pm) : cal_q.hour == 8'h23);
  assign day_wrap = hr_wrap && cal_q.date == last_day;
  always_comb begin
    cal_d = cal_q;
    cal_d.sec = sec_wrap ? 8'h00 : bcd_inc(cal_q.sec);
    if (sec_wrap) cal_d.min = min_wrap ? 8'h00 : bcd_inc(cal_q.min);
    if (min_wrap) begin
      if (!fmt12_i) cal_d.hour = hr_wrap ? 8'h00 : bcd_inc(cal_q.hour);
      else if (cal_q.hour == 8'h12) cal_d.hour = 8'h01;
      else cal_d.hour = bcd_inc(cal_q.hour);
      if (fmt12_i && cal_q.hour == 8'h11) cal_d.pm = !cal_q.pm;
    end
    if (hr_wrap) begin
      cal_d.wday = (cal_q.wday == 3'h7) ? 3'h1 : cal_q.wday + 3'h1;
      cal_d.date = day_wrap ? 8'h01 : bcd_inc(cal_q.date);
    end
    if (day_wrap) begin
      cal_d.month = (cal_q.month == 8'h12) ? 8'h01 : bcd_inc(cal_q.month);
      if (cal_q.month == 8'h12) cal_d.year = bcd_inc(cal_q.year);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cal_q <= '{YEAR_RST, MON_RST, DATE_RST, WDAY_RST, 1'b0, 8'h00,
                 8'h00, 8'h00};
    end else if (cal_load_i) cal_q <= cal_wdata_i;
    else if (sec_tick) cal_q <= cal_d;
  end
  assign cal_o = cal_q;
  assign subsec_o = prs_q;

  // ****************************************
  // Alarms
  // ****************************************
  rtcb_alarm_s alm [2];
  logic [1:0] alm_hit;
  assign alm[0] = alarm_a_i;
  assign alm[1] = alarm_b_i;
  for (genvar a = 0; a < 2; a++) begin : g_alm
    assign alm_hit[a] = alarm_en_i[a] && sec_tick && !cal_load_i &&
      (alm[a].msk[0] || alm[a].sec == cal_d.sec) &&
      (alm[a].msk[1] || alm[a].min == cal_d.min) &&
      (alm[a].msk[2] || (alm[a].hour == cal_d.hour &&
                         (!fmt12_i || alm[a].pm == cal_d.pm))) &&
      (alm[a].msk[3] || alm[a].date == cal_d.date);
  end

  // ****************************************
  // Tamper filters
  // ****************************************
  logic [NUM_TAMP-1:0] tamp_hit;
  logic [3:0] flt_lim;
  assign flt_lim = 4'h1 << tamp_flt_i;
  for (genvar t = 0; t < NUM_TAMP; t++) begin : g_tamp
    logic [3:0] cnt_q;
    logic lvl;
    assign lvl = s2_q[5 + t];
    assign tamp_hit[t] = (tamp_flt_i == 2'h0) ? pin_rise[5 + t] :
      (tick && lvl && cnt_q == flt_lim - 4'h1);
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) cnt_q <= '0;
      else if (tick) begin
        if (!lvl) cnt_q <= '0;
        else if (cnt_q < flt_lim) cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // ****************************************
  // Timestamp
  // ****************************************
  logic ts_hit;
  assign ts_hit = pin_rise[4] || (tamp_ts_en_i && |tamp_hit);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ts_cal_o <= '0;
      ts_subsec_o <= '0;
    end else if (ts_hit) begin
      ts_cal_o <= cal_q;
      ts_subsec_o <= prs_q;
    end
  end

  // ****************************************
  // Wakeup counter
  // ****************************************
  logic [WUT_W-1:0] wut_q;
  logic [3:0] wdiv_q;
  logic wu_tick, wut_hit;
  assign wu_tick = wut_1hz_i ? sec_tick : (tick && wdiv_q == WU_DIV_LAST);
  assign wut_hit = wut_en_i && wu_tick && (wut_q == '0);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wut_q <= '0;
      wdiv_q <= '0;
    end else begin
      if (tick) wdiv_q <= wdiv_q + 4'h1;
      if (!wut_en_i || wut_hit) wut_q <= wut_reload_i;
      else if (wu_tick) wut_q <= wut_q - 17'h0_0001;
    end
  end

  // ****************************************
  // Event flags and wake
  // ****************************************
  logic [NUM_FL-1:0] fl_q, fl_set;
  assign fl_set = {tamp_hit, ts_hit, wut_hit, alm_hit};
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fl_q <= '0;
      wake_o <= 1'b0;
    end else begin
      fl_q <= (fl_q & ~flag_clr_i) | fl_set;
      // wake path never gated by Stop
      wake_o <= |(((fl_q & ~flag_clr_i) | fl_set) & wake_en_i);
    end
  end
  assign flags_o = fl_q;

  // ****************************************
  // Backup words
  // ****************************************
  // sixteen 32-bit words
  logic [BKP_W-1:0] bkp_q [NUM_BKP];
  always_ff @(posedge clk_i) begin
    if (bkp_we_i) bkp_q[bkp_idx_i] <= bkp_wdata_i;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) bkp_rdata_o <= '0;
    else bkp_rdata_o <= bkp_q[bkp_idx_i];
  end
endmodule // rtcb_top

// [test/rtcb_checker.sv]
// Port checker for rtcb_top, bound after the module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rtcb_checker
  import rtcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic fmt12_i,
  input wire logic cal_load_i,
  input wire rtcb_cal_s cal_wdata_i,
  input wire logic [NUM_FL-1:0] wake_en_i,
  input wire logic [NUM_FL-1:0] flag_clr_i,
  input wire logic bkp_we_i,
  input wire logic [BKP_IDX_W-1:0] bkp_idx_i,
  input wire logic [BKP_W-1:0] bkp_wdata_i,
  input wire logic [BKP_W-1:0] bkp_rdata_o,
  input wire rtcb_cal_s cal_o,
  input wire rtcb_cal_s ts_cal_o,
  input wire logic [NUM_FL-1:0] flags_o,
  input wire logic wake_o
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_load_cal: assert property (
    cal_load_i |=> cal_o == $past(cal_wdata_i))
    else $error("calendar load not applied");
  a_bkp_read: assert property (
    bkp_we_i ##1 (!bkp_we_i && $stable(bkp_idx_i))
    |=> bkp_rdata_o == $past(bkp_wdata_i, 2))
    else $error("backup word read back wrong");
  a_sec_bcd: assert property (
    cal_o.sec[3:0] <= 4'h9 && cal_o.sec[7:4] <= 4'h5)
    else $error("seconds left BCD range");
  a_hour_24: assert property (
    !fmt12_i |-> cal_o.hour <= 8'h23 && cal_o.hour[3:0] <= 4'h9)
    else $error("hour out of 24-hour range");
  a_date_range: assert property (
    cal_o.date != 8'h00 && cal_o.date <= 8'h31 && cal_o.month != 8'h00
    && cal_o.month <= 8'h12 && (cal_o.month != 8'h02 || cal_o.date <= 8'h29))
    else $error("date or month out of range");
  a_flag_hold: assert property (
    flags_o[FL_ALRA] && !flag_clr_i[FL_ALRA] |=> flags_o[FL_ALRA])
    else $error("alarm flag dropped without clear");
  a_wake_level: assert property (
    ##1 wake_o == |(flags_o & $past(wake_en_i)))
    else $error("wake output disagrees with flags");
  a_ts_capture: assert property (
    $rose(flags_o[FL_TS]) |-> ts_cal_o == $past(cal_o))
    else $error("timestamp not equal to calendar");
endmodule // rtcb_checker

bind rtcb_top rtcb_checker u_chk (.*);

// [test/testbench.sv]
// Self-checking bench for the calendar clock block.
// Drives rtcb_top ports directly; the HSE pin is made here.
`timescale 1ns/1ps
module testbench
  import rtcb_pkg::*;
();
  logic clk_i = 0, reset_n_i = 0, xtal_clk_i = 0, lsrc_clk_i = 0;
  logic hse_clk_i, fmt12_i = 0, cal_load_i = 0, ref_en_i = 0, ref60_i = 0;
  logic ref_clk_i = 0, shift_i = 0, shift_add1s_i = 0, cal_plus_i = 0;
  logic tamp_ts_en_i = 0, ts_i = 0, wut_en_i = 0, wut_1hz_i = 0;
  logic bkp_we_i = 0, wake_o;
  rtcb_src_e src_sel_i = SRC_XTAL;
  logic [PRA_W-1:0] prediv_a_i = 7'h00;
  logic [PRS_W-1:0] prediv_s_i = 15'h0001, shift_sub_i = 15'h0000, subsec_o;
  logic [PRS_W-1:0] ts_subsec_o;
  logic [CALM_W-1:0] cal_minus_i = 9'h000;
  logic [1:0] alarm_en_i = 2'h1, tamp_flt_i = 2'h0;
  rtcb_alarm_s alarm_a_i = '{4'he, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00};
  rtcb_alarm_s alarm_b_i = '0;
  rtcb_cal_s cal_wdata_i = '0, cal_o, ts_cal_o;
  logic [NUM_TAMP-1:0] tamp_i = 3'h0;
  logic [WUT_W-1:0] wut_reload_i = 17'h0_0003;
  logic [NUM_FL-1:0] flag_clr_i = 7'h00, wake_en_i = 7'h01, flags_o;
  logic [BKP_IDX_W-1:0] bkp_idx_i = 4'h0;
  logic [BKP_W-1:0] bkp_wdata_i = '0, bkp_rdata_o;
  logic [2:0] hs_q = 3'h0;
  int fail_count = 0, checks = 0;
  // One second: two HSE ticks of 32 pin edges, pin at clk/8
  localparam int SEC_CLK = 2 * HSE_DIV * 8;
  localparam rtcb_cal_s RST_CAL = '{YEAR_RST, MON_RST, DATE_RST, WDAY_RST,
    1'b0, 8'h00, 8'h00, 8'h00};
  localparam rtcb_cal_s ST[5] = '{
    '{8'h23, 8'h12, 8'h31, 3'h7, 1'b0, 8'h23, 8'h59, 8'h59},
    '{8'h24, 8'h02, 8'h28, 3'h3, 1'b0, 8'h23, 8'h59, 8'h59},
    '{8'h23, 8'h02, 8'h28, 3'h2, 1'b0, 8'h11, 8'h59, 8'h59},
    '{8'h23, 8'h02, 8'h28, 3'h5, 1'b0, 8'h23, 8'h59, 8'h59},
    '{8'h23, 8'h04, 8'h30, 3'h1, 1'b0, 8'h23, 8'h59, 8'h59}};
  localparam rtcb_cal_s EX[5] = '{
    '{8'h24, 8'h01, 8'h01, 3'h1, 1'b0, 8'h00, 8'h00, 8'h00},
    '{8'h24, 8'h02, 8'h29, 3'h4, 1'b0, 8'h00, 8'h00, 8'h00},
    '{8'h23, 8'h02, 8'h28, 3'h2, 1'b1, 8'h12, 8'h00, 8'h00},
    '{8'h23, 8'h03, 8'h01, 3'h6, 1'b0, 8'h00, 8'h00, 8'h00},
    '{8'h23, 8'h05, 8'h01, 3'h2, 1'b0, 8'h00, 8'h00, 8'h00}};

  rtcb_top dut (.*);

  always #50 clk_i = ~clk_i;
  // HSE pin at clk/8, one tick per 256 clocks
  always @(posedge clk_i) hs_q <= hs_q + 3'h1;
  assign hse_clk_i = hs_q[2];

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_cal(input rtcb_cal_s got, input rtcb_cal_s exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: calendar %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wait_flag(input int b);
    for (int n = 0; n < 40_000 && flags_o[b] !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (flags_o[b] !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: flag %0d never set", $time, b);
    end
  endtask
  task automatic clear_flags;
    @(posedge clk_i);
    flag_clr_i <= 7'h7f;
    @(posedge clk_i);
    flag_clr_i <= 7'h00;
    #1 chk_word(32'(flags_o), 32'h0000_0000);
  endtask

  task automatic t_backup;
    for (int i = 0; i < NUM_BKP; i++) begin
      @(posedge clk_i);
      bkp_we_i <= 1'b1;
      bkp_idx_i <= 4'(i);
      bkp_wdata_i <= 32'h5a00_0000 | 32'(i * 32'h0001_0003);
    end
    @(posedge clk_i);
    bkp_we_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 chk_cal(cal_o, RST_CAL);
    for (int i = 0; i < NUM_BKP; i++) begin
      @(posedge clk_i);
      bkp_idx_i <= 4'(i);
      @(posedge clk_i);
      #1 chk_word(bkp_rdata_o, 32'h5a00_0000 | 32'(i * 32'h0001_0003));
    end
    $display("test backup done");
  endtask

  task automatic t_shift;
    logic [PRS_W-1:0] s;
    @(posedge clk_i);
    #1 s = subsec_o;
    @(posedge clk_i);
    shift_i <= 1'b1;
    shift_sub_i <= 15'h7f01;
    @(posedge clk_i);
    shift_i <= 1'b0;
    #1 chk_word(32'(subsec_o), 32'(PRS_W'(s + 15'h7f01)));
    $display("test shift done");
  endtask

  task automatic t_roll;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      fmt12_i <= (k == 2);
      cal_wdata_i <= ST[k];
      cal_load_i <= 1'b1;
      src_sel_i <= SRC_HSE32;
      @(posedge clk_i);
      cal_load_i <= 1'b0;
      #1 chk_cal(cal_o, ST[k]);
      wait_flag(FL_ALRA);
      chk_cal(cal_o, EX[k]);
      chk_word(32'(wake_o), 32'h0000_0001);
      clear_flags();
    end
    $display("test rollover done");
  endtask

  task automatic t_events;
    @(posedge clk_i);
    src_sel_i <= SRC_XTAL;
    tamp_ts_en_i <= 1'b1;
    wake_en_i <= 7'h48;
    ts_i <= 1'b1;
    wait_flag(FL_TS);
    chk_cal(ts_cal_o, EX[4]);
    chk_word(32'(ts_subsec_o), 32'(prediv_s_i));
    chk_word(32'(wake_o), 32'h0000_0001);
    clear_flags();
    @(posedge clk_i);
    tamp_i <= 3'h4;
    wait_flag(FL_TAMP + 2);
    chk_word(32'(flags_o), 32'h0000_0048);
    chk_word(32'(wake_o), 32'h0000_0001);
    $display("test events done");
  endtask

  task automatic t_wakeup;
    int n;
    @(posedge clk_i);
    src_sel_i <= SRC_HSE32;
    wut_1hz_i <= 1'b1;
    wut_en_i <= 1'b1;
    wait_flag(FL_WUT);
    clear_flags();
    n = 2;
    while (flags_o[FL_WUT] !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk_word(32'(n), 32'((int'(wut_reload_i) + 1) * SEC_CLK));
    $display("test wakeup done");
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_backup();
    t_shift();
    t_roll();
    t_events();
    t_wakeup();
    wrap_up();
  end
  // Tests need about 39000 cycles, first second alone 32768
  initial begin
    #(60_000 * 100);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // testbench
